//--- core/panel_ctrl_regs.vh
// Constants for the panel control core: register offsets, fields, resets, lock set.
// Assumes a plain single-cycle register port on one 40 MHz clock.
`ifndef PANEL_CTRL_REGS_VH
`define PANEL_CTRL_REGS_VH
// Register offsets
`define ADDR_CMD 4'h0
`define ADDR_DATA 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_START 4'h3
`define ADDR_COLPTR 4'h4
`define ADDR_MODE 4'h5
`define ADDR_WIN 4'h6
// Status fields
`define ST_DISP_ON 0
`define ST_LOCKED 1
`define ST_REMAP_COL 2
`define ST_REMAP_ROW 3
`define ST_SCAN_REV 4
// Command codes
`define CMD_DISP_OFF 8'hAE
`define CMD_DISP_ON 8'hAF
`define CMD_LOCK 8'hFD
`define CMD_REMAP 8'hA0
`define CMD_START 8'hA1
`define CMD_COLADDR 8'h15
`define LOCK_ARG_UNLOCK 8'hB1
`define LOCK_ARG_LOCK 8'hB0
// Commands held while locked
`define LK_0 8'hA2
`define LK_1 8'hB1
`define LK_2 8'hB3
`define LK_3 8'hBB
`define LK_4 8'hBE
`define LK_COUNT 5
// Reset values
`define RST_MODE 8'h00
`define RST_COL 7'h00
`define RST_START 7'h00
`define RST_WIDTH 8'h80
`define RST_HEIGHT 8'h80
`endif

//--- core/param_store.v
// Small parameter store for locked-command argument bytes, one word per entry.
// Assumes writes and reads on the same clock; read data is registered.
`timescale 1ns/1ps
module param_store #(
    parameter DEPTH = 8,
    parameter AW = 3,
    parameter DW = 8
) (
    input wire clk_i,
    input wire ce_i,
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [DW-1:0] wdata_i,
    input wire [AW-1:0] raddr_i,
    output reg [DW-1:0] rdata_o
);
    reg [DW-1:0] mem_ff [0:DEPTH-1];
    always @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_ff[waddr_i] <= wdata_i;
            end
            rdata_o <= mem_ff[raddr_i];
        end
    end
endmodule // param_store

//--- core/panel_ctrl.v
// Display driver control core: command decode, reset defaults and command lock.
// Assumes panel_reset_input_low_i is asynchronous to clk_i and is resynchronised here.
// Behaviour
// R1: Host powers logic and I/O, display off, init, clear, then panel supply.
// R2: Host waits 200 ms after panel supply on before display on.
// R3: Host sends display off before removing the panel supply.
// R4: Host waits 100 ms after panel supply off before logic supply off.
// R5: Logic and I/O supplies never removed while panel supply is on.
// R6: Reset low gives display off and full 128 by 128 RGB mode.
// R7: Reset selects normal column and row mapping and normal scan.
// R8: Reset sets start line to 0 and column counter to 0.
// R9: After reset listed commands are locked until unlock via lock command.
// R10: Host picks colour depth by parameter byte B4h or 74h.
// R11: Host resets display to recover from noise corruption.
// R12: Host finishes each transfer before next step and reports done.
`timescale 1ns/1ps
`include "panel_ctrl_regs.vh"
module panel_ctrl #(
    parameter PDEPTH = 8,
    parameter PAW = 3
) (
    input wire clk_i,
    input wire resetn_i,
    input wire ce_i,
    input wire panel_reset_input_low_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    output reg display_on_o,
    output reg locked_o,
    output reg [7:0] color_mode_o
);
    // ************************************************************
    // Reset pin synchroniser
    // ************************************************************
    reg rst_meta_ff;
    reg rst_sync_ff;
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else if (ce_i) begin
            rst_meta_ff <= panel_reset_input_low_i;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    // Either reset source forces the defaults
    wire init_w = !resetn_i || !rst_sync_ff;
    // Sync flops reset low, so defaults hold two edges past a port reset release

    // ************************************************************
    // Command decode state
    // ************************************************************
    localparam S_CMD = 2'd0;
    localparam S_ARG = 2'd1;
    reg [1:0] state_ff;
    reg [7:0] cur_cmd_ff;
    reg [PAW-1:0] arg_idx_ff;
    reg disp_ff;
    reg lock_ff;
    reg remap_col_ff;
    reg remap_row_ff;
    reg scan_rev_ff;
    reg [6:0] start_ff;
    reg [6:0] col_ff;
    reg [7:0] mode_ff;
    reg [7:0] win_ff;

    // ************************************************************
    // Lock set, one compare per entry
    // ************************************************************
    wire [7:0] lk_tab [0:`LK_COUNT-1];
    assign lk_tab[0] = `LK_0;
    assign lk_tab[1] = `LK_1;
    assign lk_tab[2] = `LK_2;
    assign lk_tab[3] = `LK_3;
    assign lk_tab[4] = `LK_4;
    wire [`LK_COUNT-1:0] hit_w;
    genvar gi;
    generate
        for (gi = 0; gi < `LK_COUNT; gi = gi + 1) begin : g_lk
            assign hit_w[gi] = (wdata_i == lk_tab[gi]);
        end
    endgenerate
    wire is_locked_cmd_w = |hit_w;

    wire cmd_wr_w = wr_i && (addr_i == `ADDR_CMD);
    wire dat_wr_w = wr_i && (addr_i == `ADDR_DATA);
    // Locked commands dropped silently; software sees nothing but no effect
    // A dropped command leaves any pending argument state untouched
    wire cmd_ok_w = cmd_wr_w && !(lock_ff && is_locked_cmd_w && wdata_i != `CMD_LOCK); // R9
    // Only arguments of lockable commands are kept
    wire store_we_w = dat_wr_w && state_ff == S_ARG && (cur_cmd_ff == `LK_1 ||
        cur_cmd_ff == `LK_2 || cur_cmd_ff == `LK_3 || cur_cmd_ff == `LK_4 ||
        cur_cmd_ff == `LK_0);

    // ************************************************************
    // Argument store
    // ************************************************************
    // Bytes are kept for the panel side only; the register port cannot
    // reach them within its one-cycle read, so the read port stays open.
    param_store #(
        .DEPTH(PDEPTH),
        .AW(PAW),
        .DW(8)
    ) u_store (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(store_we_w),
        .waddr_i(arg_idx_ff),
        .wdata_i(wdata_i),
        .raddr_i(addr_i[PAW-1:0]),
        .rdata_o()
    );

    // ************************************************************
    // Command execution
    // ************************************************************
    // Pin reset and port reset share one path so their defaults never diverge
    always @(posedge clk_i) begin
        if (init_w) begin
            state_ff <= S_CMD;
            cur_cmd_ff <= 8'h00;
            arg_idx_ff <= {PAW{1'b0}};
            disp_ff <= 1'b0; // R6
            win_ff <= `RST_WIDTH; // R6
            mode_ff <= `RST_MODE; // R6
            remap_col_ff <= 1'b0; // R7
            remap_row_ff <= 1'b0; // R7
            scan_rev_ff <= 1'b0; // R7
            start_ff <= `RST_START; // R8
            col_ff <= `RST_COL; // R8
            lock_ff <= 1'b1; // R9
        end else if (ce_i) begin
            if (cmd_ok_w) begin
                cur_cmd_ff <= wdata_i;
                arg_idx_ff <= {PAW{1'b0}};
                if (wdata_i == `CMD_DISP_OFF) begin
                    disp_ff <= 1'b0;
                    state_ff <= S_CMD;
                end else if (wdata_i == `CMD_DISP_ON) begin
                    disp_ff <= 1'b1;
                    state_ff <= S_CMD;
                end else begin
                    state_ff <= S_ARG;
                end
            end else if (dat_wr_w && state_ff == S_ARG) begin
                arg_idx_ff <= arg_idx_ff + {{(PAW-1){1'b0}}, 1'b1};
                case (cur_cmd_ff)
                    `CMD_LOCK: begin
                        // Only the unlock and relock arguments change the lock
                        if (wdata_i == `LOCK_ARG_UNLOCK) begin
                            lock_ff <= 1'b0; // R9
                        end else if (wdata_i == `LOCK_ARG_LOCK) begin
                            lock_ff <= 1'b1; // R9
                        end
                    end
                    `CMD_REMAP: begin
                        // Whole byte is kept as the colour mode as well
                        remap_col_ff <= wdata_i[1];
                        scan_rev_ff <= wdata_i[4];
                        remap_row_ff <= wdata_i[5];
                        mode_ff <= wdata_i;
                    end
                    `CMD_START: begin
                        start_ff <= wdata_i[6:0];
                    end
                    `CMD_COLADDR: begin
                        // Only the start column is kept; the end column is unused
                        if (arg_idx_ff == {PAW{1'b0}}) begin
                            col_ff <= wdata_i[6:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Register read port and outputs
    // ************************************************************
    reg [7:0] nxt_rdata;
    always @* begin
        nxt_rdata = 8'h00;
        if (addr_i == `ADDR_STATUS) begin
            nxt_rdata = {3'b000, scan_rev_ff, remap_row_ff, remap_col_ff, lock_ff, disp_ff};
        end else if (addr_i == `ADDR_START) begin
            nxt_rdata = {1'b0, start_ff};
        end else if (addr_i == `ADDR_COLPTR) begin
            nxt_rdata = {1'b0, col_ff};
        end else if (addr_i == `ADDR_MODE) begin
            nxt_rdata = mode_ff;
        end else if (addr_i == `ADDR_WIN) begin
            nxt_rdata = win_ff;
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    // Outputs lag the internal state by one edge
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
            display_on_o <= 1'b0;
            locked_o <= 1'b1;
            color_mode_o <= `RST_MODE;
        end else if (ce_i) begin
            // Cleared outside the read cycle while ce_i is high; with ce_i low the last read value holds
            rdata_o <= rd_i ? nxt_rdata : 8'h00;
            display_on_o <= disp_ff;
            locked_o <= lock_ff;
            color_mode_o <= mode_ff;
        end
    end
endmodule // panel_ctrl

//--- bench/panel_ctrl_chk.sv
// Checker: reset defaults and command lock of panel_ctrl.
// Assumes one clock; bound to every panel_ctrl instance.
`timescale 1ns/1ps
module panel_ctrl_chk (
    input wire clk_i,
    input wire resetn_i,
    input wire ce_i,
    input wire panel_reset_input_low_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire display_on_o,
    input wire locked_o,
    input wire [7:0] color_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rst;
        $rose(resetn_i) |-> !display_on_o && locked_o && color_mode_o == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_pin;
        (!panel_reset_input_low_i && ce_i)[*4] |=> !display_on_o && locked_o;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset ignored");
    // Defaults seen through reads shortly after a pin reset
    property p_pin_rd;
        (!panel_reset_input_low_i)[*4] ##[1:12]
            (rd_i && ce_i && addr_i inside {4'h2, 4'h3, 4'h4})
            |=> rdata_o == ($past(addr_i) == 4'h2 ? 8'h02 : 8'h00);
    endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("bad default read");
    property p_unlock;
        $fell(locked_o) |-> $past(wr_i && addr_i == 4'h1 && wdata_i == 8'hB1, 2)
            && $past(wr_i && addr_i == 4'h0 && wdata_i == 8'hFD, 3);
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock without command");
endmodule // panel_ctrl_chk
bind panel_ctrl panel_ctrl_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .panel_reset_input_low_i(panel_reset_input_low_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .display_on_o(display_on_o),
    .locked_o(locked_o), .color_mode_o(color_mode_o));

//--- bench/host_model.sv
// Host model: drives the register port and the panel reset pin.
// Assumes the bench pops read expectations from exp_q.
`timescale 1ns/1ps
module host_model #(
    parameter SETTLE = 20,
    parameter DISCH = 10
) (
    input wire clk_i,
    output reg [3:0] addr_o = 4'h0,
    output reg [7:0] wdata_o = 8'h00,
    output reg wr_o = 1'b0,
    output reg rd_o = 1'b0,
    output reg rst_pin_n_o = 1'b1
);
    logic [7:0] exp_q[$];
    // One whole transfer per edge before the next step
    task automatic xfer(input w, input [3:0] a, input [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
    endtask
    task automatic rd(input [3:0] a, input [7:0] e);
        xfer(1'b0, a, 8'h00);
        exp_q.push_back(e);
    endtask
    // Released data lines show the inverse, not a stale copy
    task automatic idle(input integer n);
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        wdata_o <= ~wdata_o;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic power_up(input [7:0] mode);
        xfer(1'b1, 4'h0, 8'hAE);
        xfer(1'b1, 4'h0, 8'hFD);
        xfer(1'b1, 4'h1, 8'hB1);
        xfer(1'b1, 4'h0, 8'hA0);
        xfer(1'b1, 4'h1, mode);
        idle(SETTLE);
        xfer(1'b1, 4'h0, 8'hAF);
    endtask
    // Panel supply drops after display off, logic supply after discharge
    task automatic power_down;
        xfer(1'b1, 4'h0, 8'hAE);
        idle(DISCH);
    endtask
    task automatic pin_reset;
        idle(0);
        rst_pin_n_o <= 1'b0;
        idle(4);
        rst_pin_n_o <= 1'b1;
        idle(4);
    endtask
endmodule // host_model

//--- bench/panel_ctrl_tb_top.sv
// Bench: host model drives panel_ctrl; reads checked from a queue.
// Assumes host_model, panel_ctrl and its checker are compiled first.
`timescale 1ns/1ps
module panel_ctrl_tb_top;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rd_d = 1'b0;
    logic ce = 1'b1;
    logic [31:0] seed = 32'h71C1A081;
    integer n_mismatch = 0;
    integer num_checks = 0;
    integer cyc = 0;
    wire [3:0] addr;
    wire [7:0] wdata, rdata, cmode;
    wire wr, rd, pin_n, disp, lck;
    always #12.5 clk_i = ~clk_i;
    host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rst_pin_n_o(pin_n));
    panel_ctrl DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
        .panel_reset_input_low_i(pin_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .display_on_o(disp), .locked_o(lck),
        .color_mode_o(cmode));
    function automatic [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input [7:0] seen, input [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        rd_d <= rd;
        if (rd_d) begin
            check(rdata, host.exp_q.pop_front());
        end
        if (cyc == 2000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic defaults;
        host.rd(4'h2, 8'h02);
        host.rd(4'h3, 8'h00);
        host.rd(4'h4, 8'h00);
        host.rd(4'h6, 8'h80);
        host.idle(2);
        #1 check({6'h00, disp, lck}, 8'h01);
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        defaults();
        // Locked command must not steal the argument of the pending remap
        seed = xs(seed);
        host.xfer(1'b1, 4'h0, 8'hA0);
        host.xfer(1'b1, 4'h1, 8'h00);
        host.xfer(1'b1, 4'h0, 8'hB1);
        host.xfer(1'b1, 4'h1, {1'b1, seed[6:0]});
        host.rd(4'h5, {1'b1, seed[6:0]});
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            host.rd({1'b1, seed[2:0]}, 8'h00);
            host.power_up(i ? 8'hB4 : 8'h74);
            host.xfer(1'b1, 4'h0, 8'hA1);
            host.xfer(1'b1, 4'h1, seed[15:8]);
            host.xfer(1'b1, 4'h0, 8'h15);
            host.xfer(1'b1, 4'h1, seed[23:16]);
            host.rd(4'h3, {1'b0, seed[14:8]});
            host.rd(4'h4, {1'b0, seed[22:16]});
            host.rd(4'h5, i ? 8'hB4 : 8'h74);
            host.idle(2);
            #1 check({6'h00, disp, lck}, 8'h02);
            check(cmode, i ? 8'hB4 : 8'h74);
            // Clock enable low: a display-off write must leave the display on and the lock open
            @(posedge clk_i);
            ce <= 1'b0;
            host.xfer(1'b1, 4'h0, 8'hAE);
            host.idle(2);
            #1 check({6'h00, disp, lck}, 8'h02);
            @(posedge clk_i);
            ce <= 1'b1;
            host.power_down();
            host.pin_reset();
            defaults();
        end
        host.power_up(8'hB4);
        host.idle(0);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        defaults();
        conclude();
    end
endmodule // panel_ctrl_tb_top
